// >>> design/dual_prescaled_timer_sync.sv
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module dual_prescaled_timer_sync (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	// Avalon-MM slave
	input wire logic [dual_timer_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [dual_timer_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [dual_timer_pkg::DATA_W-1:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// Pulse-period measurement input pin
	input wire logic I_A_EDGE_PIN,
	// Interrupt
	output logic O_IRQ
);
	import dual_timer_pkg::*;

	// ----------------------------------------------------------------
	// Bus access decode
	// ----------------------------------------------------------------
	wire req = I_AVS_READ || I_AVS_WRITE;
	wire acc = req && !O_AVS_WAITREQUEST;
	wire wr = acc && I_AVS_WRITE;
	wire lo = I_AVS_BYTEENABLE[0];
	wire [7:0] wd = I_AVS_WRITEDATA[7:0];
	wire wr_a_ctrl = wr && lo && (I_AVS_ADDRESS == OFF_A_CTRL);
	wire wr_a_pre = wr && lo && (I_AVS_ADDRESS == OFF_A_PRE);
	wire wr_a_cnt = wr && lo && (I_AVS_ADDRESS == OFF_A_CNT);
	wire wr_b_ctrl = wr && lo && (I_AVS_ADDRESS == OFF_B_CTRL);
	wire wr_b_os = wr && lo && (I_AVS_ADDRESS == OFF_B_OS);
	wire wr_b_pre = wr && lo && (I_AVS_ADDRESS == OFF_B_PRE);
	wire wr_b_prim = wr && lo && (I_AVS_ADDRESS == OFF_B_PRIM);
	wire wr_stat = wr && lo && (I_AVS_ADDRESS == OFF_IRQ_STAT);
	wire wr_mask = wr && lo && (I_AVS_ADDRESS == OFF_IRQ_MASK);
	wire wr_div = wr && (I_AVS_ADDRESS == OFF_DIV);

	// ----------------------------------------------------------------
	// Count source divider
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_limit;
	logic [DIV_W-1:0] div_cnt;
	wire tick = (div_cnt == '0);

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			div_cnt <= RST_DIV;
		end else begin
			div_cnt <= tick ? div_limit : div_cnt - DIV_W'(1);
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			div_limit <= RST_DIV;
		end else if (wr_div) begin
			if (I_AVS_BYTEENABLE[0]) begin
				div_limit[7:0] <= I_AVS_WRITEDATA[7:0];
			end
			if (I_AVS_BYTEENABLE[1]) begin
				div_limit[15:8] <= I_AVS_WRITEDATA[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Edge pin synchroniser and edge detect
	// ----------------------------------------------------------------
	logic edge_s1;
	logic edge_s2;
	logic edge_s3;
	wire pin_rise = edge_s2 && !edge_s3;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			edge_s1 <= 1'b0;
			edge_s2 <= 1'b0;
			edge_s3 <= 1'b0;
		end else begin
			edge_s1 <= I_A_EDGE_PIN;
			edge_s2 <= edge_s1;
			edge_s3 <= edge_s2;
		end
	end

	// ----------------------------------------------------------------
	// A timer control
	// ----------------------------------------------------------------
	logic a_run;
	logic a_active;
	logic a_ppm;
	logic a_edge_seen;
	logic a_under_seen;
	logic [7:0] a_pre_rl;
	logic [7:0] a_cnt_rl;
	logic [7:0] a_pre;
	logic [7:0] a_cnt;
	logic a_pre_uf;
	logic a_cnt_uf;
	wire a_edge_evt = a_ppm && a_active && pin_rise;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			a_run <= 1'b0;
			a_ppm <= 1'b0;
		end else if (wr_a_ctrl) begin
			a_run <= wd[BIT_RUN];
			a_ppm <= wd[BIT_A_PPM];
		end
	end

	// The active flag samples the request only on a count-source tick.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			a_active <= 1'b0;
		end else if (tick) begin
			a_active <= a_run;
		end
	end

	// Hardware set wins over a software clear in the same cycle.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			a_edge_seen <= 1'b0;
			a_under_seen <= 1'b0;
		end else begin
			a_edge_seen <= a_edge_evt || (a_edge_seen && !(wr_a_ctrl && !wd[BIT_EDGE]));
			a_under_seen <= a_cnt_uf || (a_under_seen && !(wr_a_ctrl && !wd[BIT_UNDER]));
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			a_pre_rl <= RST_PRE;
			a_cnt_rl <= RST_CNT;
		end else begin
			if (wr_a_pre) begin
				a_pre_rl <= wd;
			end
			if (wr_a_cnt) begin
				a_cnt_rl <= wd;
			end
		end
	end

	// While counting, a written value waits in the reload register for the next underflow; in pulse-period mode the counter also takes it on a pin edge.
	prescaled_down_counter #(
		.PW(8),
		.CW(8)
	) u_a_cnt (
		.i_clk(I_CLK),
		.i_arst_n(I_ARST_N),
		.i_tick(tick),
		.i_run(a_active),
		.i_load_pre(wr_a_pre && !a_active),
		.i_load_cnt(wr_a_cnt && !a_active),
		.i_restart_cnt(a_edge_evt),
		.i_reload_all(1'b0),
		.i_pre_value(wd),
		.i_cnt_value(wd),
		.i_pre_reload(a_pre_rl),
		.i_cnt_reload(a_cnt_rl),
		.o_pre(a_pre),
		.o_cnt(a_cnt),
		.o_pre_uf(a_pre_uf),
		.o_cnt_uf(a_cnt_uf)
	);

	// ----------------------------------------------------------------
	// B timer control
	// ----------------------------------------------------------------
	b_mode_t b_mode;
	logic b_run;
	logic b_run_s1;
	logic b_active;
	logic b_os_arm;
	logic b_os_status;
	logic os_start_pend;
	logic os_stop_pend;
	logic os_start_s1;
	logic os_stop_s1;
	logic [7:0] b_pre_rl;
	logic [7:0] b_prim_rl;
	logic [7:0] b_pre;
	logic [7:0] b_prim;
	logic b_pre_uf;
	logic b_prim_uf;
	wire b_os_mode = (b_mode == B_ONESHOT) || (b_mode == B_WAIT_ONESHOT);
	wire b_halt_now = wr_b_ctrl && wd[BIT_HALT];
	wire b_os_start_wr = wr_b_os && wd[BIT_OS_START];
	wire b_os_stop_wr = wr_b_os && wd[BIT_OS_STOP];
	wire b_run_clear = wr_b_ctrl && !wd[BIT_RUN] && b_run;
	wire b_os_abort = b_os_mode && (b_os_stop_wr || b_run_clear);
	wire b_os_done = b_os_mode && b_prim_uf;
	wire b_count = b_active && (!b_os_mode || (b_os_arm && b_os_status));

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			b_run <= 1'b0;
			b_mode <= B_TIMER;
		end else if (wr_b_ctrl) begin
			b_run <= wd[BIT_RUN] && !wd[BIT_HALT];
			b_mode <= b_mode_t'(wd[BIT_B_MODE_LO +: 2]);
		end
	end

	// Two tick-enabled stages; forced halt bypasses both.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			b_run_s1 <= 1'b0;
			b_active <= 1'b0;
		end else if (b_halt_now) begin
			b_run_s1 <= 1'b0;
			b_active <= 1'b0;
		end else if (tick) begin
			b_run_s1 <= b_run;
			b_active <= b_run_s1;
		end
	end

	// The arm gate halts a one-shot at once; the status flag follows later.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			b_os_arm <= 1'b0;
		end else if (b_os_abort || b_os_done || b_halt_now) begin
			b_os_arm <= 1'b0;
		end else if (b_os_start_wr) begin
			b_os_arm <= 1'b1;
		end
	end

	// One-shot requests wait for a tick, then take one more to reach the status flag.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			os_start_pend <= 1'b0;
			os_stop_pend <= 1'b0;
		end else begin
			os_start_pend <= b_os_start_wr || (os_start_pend && !tick);
			os_stop_pend <= b_os_stop_wr || b_os_abort || b_os_done || (os_stop_pend && !tick);
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			os_start_s1 <= 1'b0;
			os_stop_s1 <= 1'b0;
			b_os_status <= 1'b0;
		end else if (tick) begin
			os_start_s1 <= os_start_pend;
			os_stop_s1 <= os_stop_pend;
			if (os_stop_s1) begin
				b_os_status <= 1'b0;
			end else if (os_start_s1) begin
				b_os_status <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			b_pre_rl <= RST_PRE;
			b_prim_rl <= RST_CNT;
		end else begin
			if (wr_b_pre) begin
				b_pre_rl <= wd;
			end
			if (wr_b_prim) begin
				b_prim_rl <= wd;
			end
		end
	end

	prescaled_down_counter #(
		.PW(8),
		.CW(8)
	) u_b_cnt (
		.i_clk(I_CLK),
		.i_arst_n(I_ARST_N),
		.i_tick(tick),
		.i_run(b_count),
		.i_load_pre(wr_b_pre && !b_active),
		.i_load_cnt(wr_b_prim && !b_active),
		.i_restart_cnt(1'b0),
		.i_reload_all(b_os_abort),
		.i_pre_value(wd),
		.i_cnt_value(wd),
		.i_pre_reload(b_pre_rl),
		.i_cnt_reload(b_prim_rl),
		.o_pre(b_pre),
		.o_cnt(b_prim),
		.o_pre_uf(b_pre_uf),
		.o_cnt_uf(b_prim_uf)
	);

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	wire [IRQ_W-1:0] irq_evt = {b_prim_uf, a_edge_evt, a_cnt_uf};
	wire [IRQ_W-1:0] irq_clr = wr_stat ? wd[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] next_irq_stat = irq_evt | (irq_stat & ~irq_clr);

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			irq_stat <= '0;
			irq_mask <= '0;
			O_IRQ <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_mask <= wr_mask ? wd[IRQ_W-1:0] : irq_mask;
			O_IRQ <= |(next_irq_stat & (wr_mask ? wd[IRQ_W-1:0] : irq_mask));
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer and wait-state generator
	// ----------------------------------------------------------------
	wire [7:0] a_ctrl_rd = {3'h0, a_ppm, a_under_seen, a_edge_seen, a_active, a_run};
	wire [7:0] b_ctrl_rd = {2'h0, b_mode, 2'h0, b_active, b_run};
	wire [7:0] b_os_rd = {5'h00, b_os_status, 2'h0};
	logic [DATA_W-1:0] rd_mux;

	// Each timer value is its own register, so a wide read is two separate samples.
	always_comb begin
		rd_mux = '0;
		unique case (I_AVS_ADDRESS)
			OFF_A_CTRL: rd_mux[7:0] = a_ctrl_rd;
			OFF_A_PRE: rd_mux[7:0] = a_pre;
			OFF_A_CNT: rd_mux[7:0] = a_cnt;
			OFF_B_CTRL: rd_mux[7:0] = b_ctrl_rd;
			OFF_B_OS: rd_mux[7:0] = b_os_rd;
			OFF_B_PRE: rd_mux[7:0] = b_pre;
			OFF_B_PRIM: rd_mux[7:0] = b_prim;
			OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
			OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
			OFF_DIV: rd_mux[DIV_W-1:0] = div_limit;
			default: rd_mux = '0;
		endcase
	end

	// Every access sees exactly one wait state.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_AVS_WAITREQUEST <= 1'b1;
			O_AVS_READDATA <= '0;
		end else begin
			O_AVS_WAITREQUEST <= !(req && O_AVS_WAITREQUEST);
			if (I_AVS_READ && O_AVS_WAITREQUEST) begin
				O_AVS_READDATA <= rd_mux;
			end
		end
	end

endmodule

// >>> design/dual_timer_pkg.sv
// Function
// - The A timer is halted after reset and software loads its prescaler and counter before starting it.
// - The prescaler and counter of a timer are read as separate narrow accesses, so they may change in between.
// - The A edge-seen and underflow-seen flags clear on a written zero and keep their value on a written one.
// - An A start leaves the count-active flag low for 0 to 1 count-source cycle; counting then follows.
// - An A stop leaves the count-active flag high for 0 to 1 count-source cycle; counting halts with it.
// - The B timer is halted after reset and software loads its prescaler and counter before starting it.
// - In one-shot modes a cleared run request or a one-shot stop reloads the B counter and halts it.
// - A B start leaves the count-active flag low for 1 to 2 count-source cycles; counting then follows, in one-shot modes after a one-shot start.
// - A B stop leaves the count-active flag high for 1 to 2 count-source cycles; counting halts with it, or at once in one-shot modes.
// - Setting the B forced-halt bit stops the B timer at once, with no synchronisation delay.
// - A one-shot start or stop changes the one-shot status flag after one or two count-source cycles.
package dual_timer_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DIV_W = 16;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_A_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_A_PRE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_A_CNT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_B_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_B_OS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_B_PRE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_B_PRIM = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_DIV = 8'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_RUN = 0;
	localparam int BIT_ACTIVE = 1;
	localparam int BIT_EDGE = 2;
	localparam int BIT_UNDER = 3;
	localparam int BIT_A_PPM = 4;
	localparam int BIT_HALT = 2;
	localparam int BIT_B_MODE_LO = 4;
	localparam int BIT_OS_START = 0;
	localparam int BIT_OS_STOP = 1;
	localparam int BIT_OS_STAT = 2;
	localparam int IRQ_A_UNDER = 0;
	localparam int IRQ_A_EDGE = 1;
	localparam int IRQ_B_UNDER = 2;
	localparam int IRQ_W = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_PRE = 8'hFF;
	localparam logic [7:0] RST_CNT = 8'hFF;
	localparam logic [DIV_W-1:0] RST_DIV = 16'h0007;

	typedef enum logic [1:0] {
		B_TIMER,
		B_ONESHOT,
		B_WAIT_ONESHOT,
		B_SPARE
	} b_mode_t;

endpackage

// >>> design/prescaled_down_counter.sv
`timescale 1ns/1ps
module prescaled_down_counter #(
	parameter int PW = 8,
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Control
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic i_load_pre,
	input wire logic i_load_cnt,
	input wire logic i_restart_cnt,
	input wire logic i_reload_all,
	input wire logic [PW-1:0] i_pre_value,
	input wire logic [CW-1:0] i_cnt_value,
	input wire logic [PW-1:0] i_pre_reload,
	input wire logic [CW-1:0] i_cnt_reload,
	// State
	output logic [PW-1:0] o_pre,
	output logic [CW-1:0] o_cnt,
	output logic o_pre_uf,
	output logic o_cnt_uf
);
	import dual_timer_pkg::*;

	wire step = i_tick && i_run;

	assign o_pre_uf = step && (o_pre == '0);
	assign o_cnt_uf = o_pre_uf && (o_cnt == '0);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pre <= PW'(RST_PRE);
		end else if (i_load_pre) begin
			o_pre <= i_pre_value;
		end else if (i_reload_all) begin
			o_pre <= i_pre_reload;
		end else if (step) begin
			o_pre <= o_pre_uf ? i_pre_reload : o_pre - PW'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cnt <= CW'(RST_CNT);
		end else if (i_load_cnt) begin
			o_cnt <= i_cnt_value;
		end else if (i_reload_all || i_restart_cnt) begin
			o_cnt <= i_cnt_reload;
		end else if (o_pre_uf) begin
			o_cnt <= o_cnt_uf ? i_cnt_reload : o_cnt - CW'(1);
		end
	end

endmodule

// >>> tb/dual_timer_properties.sv
`timescale 1ns/1ps
module dual_timer_properties (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [dual_timer_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [dual_timer_pkg::DATA_W-1:0] O_AVS_READDATA,
	input wire logic O_AVS_WAITREQUEST,
	input wire logic O_IRQ
);
	import dual_timer_pkg::*;
	wire req = I_AVS_READ || I_AVS_WRITE;
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);
	a_wait_idle_high: assert property (!req |-> O_AVS_WAITREQUEST)
		else $error("waitrequest low with no request");
	a_wait_answers: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("request not answered next cycle");
	a_wait_one_cycle: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	a_wait_has_cause: assert property (!O_AVS_WAITREQUEST |-> $past(req))
		else $error("answer without earlier request");
	a_rdata_holds: assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_READ))
		else $error("read data changed without read");
	a_rdata_narrow: assert property (O_AVS_READDATA[31:16] == 16'h0000)
		else $error("unused read data bits set");
	a_unmapped_zero: assert property (I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS > OFF_DIV
		|-> O_AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	a_irq_clear_write: assert property ($fell(O_IRQ) |-> $past(I_AVS_WRITE) || $past(I_AVS_WRITE, 2)
		|| $past(I_AVS_WRITE, 3))
		else $error("interrupt fell without a write");
endmodule
bind dual_prescaled_timer_sync dual_timer_properties dual_timer_properties_i (.I_CLK, .I_ARST_N,
	.I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .O_IRQ);

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import dual_timer_pkg::*;
	logic clk, arst_n, rd, wr, wait_r, irq, pin;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, v, c1;
	int mismatches = 0;
	int total_checks = 0;
	dual_prescaled_timer_sync dual_prescaled_timer_sync_i (.I_CLK(clk), .I_ARST_N(arst_n),
		.I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
		.I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_r),
		.I_A_EDGE_PIN(pin), .O_IRQ(irq));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One bus cycle; the request is held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		while (wait_r !== 1'b0) begin
			n++;
			if (n > 50) begin
				mismatches++;
				end_sim();
			end
			@(posedge clk);
		end
		v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		bus(1'b0, a, 32'h0);
		check(v, exp);
	endtask
	task automatic bitchk(input logic [ADDR_W-1:0] a, input int b, input logic val);
		bus(1'b0, a, 32'h0);
		check({31'h0, v[b]}, {31'h0, val});
	endtask
	// Reads a flag until it takes the expected level, a bounded number of times.
	task automatic poll(input logic [ADDR_W-1:0] a, input int b, input logic val);
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, a, 32'h0);
			if (v[b] === val) break;
		end
		check({31'h0, v[b]}, {31'h0, val});
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(OFF_A_CTRL, 32'h0);
		rchk(OFF_A_CNT, {24'h0, RST_CNT});
		rchk(OFF_B_CTRL, 32'h0);
		rchk(OFF_B_PRE, {24'h0, RST_PRE});
		rchk(OFF_DIV, {16'h0, RST_DIV});
		bus(1'b1, 8'h30, 32'h55);
		rchk(8'h30, 32'h0);
	endtask
	task automatic t_a_run();
		bus(1'b1, OFF_DIV, 32'h3);
		bus(1'b1, OFF_A_PRE, 32'h3);
		bus(1'b1, OFF_A_CNT, 32'h40);
		bus(1'b1, OFF_A_CTRL, 32'h1);
		poll(OFF_A_CTRL, BIT_ACTIVE, 1'b1);
		bus(1'b0, OFF_A_CNT, 32'h0);
		c1 = v;
		repeat (40) @(posedge clk);
		bus(1'b0, OFF_A_CNT, 32'h0);
		check(32'(v !== c1), 32'h1);
		bus(1'b1, OFF_A_CTRL, 32'h0);
		poll(OFF_A_CTRL, BIT_ACTIVE, 1'b0);
		bus(1'b0, OFF_A_PRE, 32'h0);
		check(32'(v <= 32'h3), 32'h1);
		bus(1'b0, OFF_A_CNT, 32'h0);
		c1 = v;
		repeat (20) @(posedge clk);
		rchk(OFF_A_CNT, c1);
	endtask
	task automatic t_b_run();
		bus(1'b1, OFF_B_PRE, 32'h1);
		bus(1'b1, OFF_B_PRIM, 32'h40);
		bus(1'b1, OFF_B_CTRL, 32'h1);
		bitchk(OFF_B_CTRL, BIT_ACTIVE, 1'b0);
		poll(OFF_B_CTRL, BIT_ACTIVE, 1'b1);
		bus(1'b1, OFF_B_CTRL, 32'h4);
		bus(1'b0, OFF_B_PRIM, 32'h0);
		c1 = v;
		repeat (24) @(posedge clk);
		rchk(OFF_B_PRIM, c1);
		bitchk(OFF_B_CTRL, BIT_RUN, 1'b0);
		poll(OFF_B_CTRL, BIT_ACTIVE, 1'b0);
		bus(1'b1, OFF_B_CTRL, 32'h1);
		poll(OFF_B_CTRL, BIT_ACTIVE, 1'b1);
		bus(1'b1, OFF_B_CTRL, 32'h0);
		bitchk(OFF_B_CTRL, BIT_ACTIVE, 1'b1);
		poll(OFF_B_CTRL, BIT_ACTIVE, 1'b0);
	endtask
	task automatic t_oneshot();
		bus(1'b1, OFF_B_PRIM, 32'h40);
		bus(1'b1, OFF_B_CTRL, 32'h11);
		poll(OFF_B_CTRL, BIT_ACTIVE, 1'b1);
		for (int k = 0; k < 2; k++) begin
			if (k) bus(1'b1, OFF_B_CTRL, 32'h21);
			bus(1'b1, OFF_B_OS, 32'h1);
			bitchk(OFF_B_OS, BIT_OS_STAT, 1'b0);
			poll(OFF_B_OS, BIT_OS_STAT, 1'b1);
			repeat (40) @(posedge clk);
			bus(1'b0, OFF_B_PRIM, 32'h0);
			check(32'(v !== 32'h40), 32'h1);
			bus(1'b1, k ? OFF_B_CTRL : OFF_B_OS, k ? 32'h20 : 32'h2);
			if (k) poll(OFF_B_CTRL, BIT_ACTIVE, 1'b0);
			rchk(OFF_B_PRIM, 32'h40);
			poll(OFF_B_OS, BIT_OS_STAT, 1'b0);
		end
		bus(1'b1, OFF_B_CTRL, 32'h0);
	endtask
	task automatic t_flags();
		bus(1'b1, OFF_DIV, 32'h0);
		bus(1'b1, OFF_A_PRE, 32'h1);
		bus(1'b1, OFF_A_CNT, 32'h3);
		bus(1'b1, OFF_A_CTRL, 32'h10);
		bus(1'b1, OFF_A_CTRL, 32'h11);
		poll(OFF_A_CTRL, BIT_ACTIVE, 1'b1);
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		pin <= 1'b0;
		repeat (40) @(posedge clk);
		rchk(OFF_A_CTRL, 32'h1F);
		bus(1'b1, OFF_IRQ_MASK, 32'h0);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, OFF_IRQ_MASK, 32'h3);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		bus(1'b1, OFF_A_CTRL, 32'h1C);
		poll(OFF_A_CTRL, BIT_ACTIVE, 1'b0);
		rchk(OFF_A_CTRL, 32'h1C);
		bus(1'b1, OFF_A_CTRL, 32'h10);
		rchk(OFF_A_CTRL, 32'h10);
		bus(1'b1, OFF_IRQ_STAT, 32'h7);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
	endtask
	initial begin
		arst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		pin = 1'b0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_a_run();
		t_b_run();
		t_oneshot();
		t_flags();
		end_sim();
	end
endmodule
